// file: pkg/fdcr_pkg.sv
package fdcr_pkg;
    localparam logic [7:0] ADDR_DRV_IF  = 8'hF0;
    localparam logic [7:0] ADDR_BOOT_WR = 8'hF1;
    localparam logic [7:0] ADDR_DTYPE   = 8'hF2;
    localparam logic [7:0] ADDR_DRV0X   = 8'hF4;
    localparam logic [7:0] RST_DRV_IF   = 8'h8E;
    localparam logic [7:0] RST_BOOT_WR  = 8'h00;
    localparam logic [7:0] RST_DTYPE    = 8'hFF;
    localparam logic [7:0] RST_DRV0X    = 8'h00;
    localparam logic [7:0] MASK_DRV0X   = 8'h5B;
    localparam logic [7:0] READ_IDLE    = 8'h00;
    localparam int B_PULL_DIS   = 7;
    localparam int B_POL_HIGH   = 6;
    localparam int B_DRV2_N     = 5;
    localparam int B_SWAP       = 4;
    localparam int B_MODE_HI    = 3;
    localparam int B_MODE_LO    = 2;
    localparam int B_NONBURST   = 1;
    localparam int B_THREE_MODE = 0;
    localparam int B_BOOT_HI    = 7;
    localparam int B_BOOT_LO    = 6;
    localparam int B_MEDIA_HI   = 5;
    localparam int B_MEDIA_LO   = 4;
    localparam int B_DENS_HI    = 3;
    localparam int B_DENS_LO    = 2;
    localparam int B_WR_INH     = 1;
    localparam int B_FORCE_WP   = 0;
    localparam int B_PRECOMP_DIS = 6;
    localparam int B_RATE_HI    = 4;
    localparam int B_RATE_LO    = 3;
    localparam int B_D0TYPE_HI  = 1;
    localparam int B_D0TYPE_LO  = 0;
    localparam int B_TAPE_HI    = 5;
    localparam logic [1:0] MODE_COMPACT = 2'h0;
    localparam logic [1:0] MODE_SECOND  = 2'h1;
    localparam logic [1:0] MODE_RSVD    = 2'h2;
    localparam logic [1:0] MODE_AT      = 2'h3;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [4:0] PIN_IN_IDLE = 5'h1F;
    localparam logic [4:0] RST_CORE_IN = 5'h00;
    localparam logic [7:0] RST_TAPE    = 8'h00;
    localparam logic LEVEL_ON = 1'b1;
    localparam int IN_READ_DATA     = 0;
    localparam int IN_INDEX         = 1;
    localparam int IN_TRACK_ZERO    = 2;
    localparam int IN_DISK_CHANGED  = 3;
    localparam int IN_WRITE_PROTECT = 4;
    typedef enum logic [1:0] {
        DMA_IDLE = 2'b01,
        DMA_GAP  = 2'b10
    } fdcr_dma_t;
endpackage

// file: hw/fdcr_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: Config bit 7 low turns input pull-ups on.
// R2: Config bit 6 sets drive signal polarity.
// R3: Bit 5 low reports second drive, second mode.
// R4: Bit 4 swaps drive and motor selects 0/1.
// R5: Bit 1 picks burst or non-burst DMA.
// R6: Bit 0 selects enhanced three-mode drive operation.
// R7: Media ID bits read back in tape register.
// R8: Write inhibit holds write gate, data high.
// R9: Force bit makes medium always write protected.
// R10: Bits 3..2 select interface mode, 10 reserved.
// R11: Drive type register holds four 2-bit fields.
module fdcr_top (
    input  wire logic       SYS_CLK,
    input  wire logic       ARST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic [1:0] CORE_DRIVE_SEL,
    input  wire logic [1:0] CORE_MOTOR_ON,
    input  wire logic       CORE_WRITE_GATE,
    input  wire logic       CORE_WRITE_DATA,
    input  wire logic       CORE_DRQ,
    input  wire logic       DMA_ACK,
    input  wire logic [5:0] CORE_TAPE_LOW,
    input  wire logic       READ_DATA_IN,
    input  wire logic       INDEX_IN,
    input  wire logic       TRACK_ZERO_IN,
    input  wire logic       DISK_CHANGED_IN,
    input  wire logic       WRITE_PROTECT_IN,
    output logic      [1:0] DRIVE_SEL_OUT,
    output logic      [1:0] MOTOR_OUT,
    output logic            WRITE_GATE_OUT,
    output logic            WRITE_DATA_OUT,
    output logic            INPUT_PULLUP_EN,
    output logic            CORE_READ_DATA,
    output logic            CORE_INDEX,
    output logic            CORE_TRACK_ZERO,
    output logic            CORE_DISK_CHANGED,
    output logic            CORE_WRITE_PROTECT,
    output logic            SRA_SECOND_DRIVE,
    output logic      [1:0] INTERFACE_MODE,
    output logic            DMA_NONBURST,
    output logic            DMA_REQ,
    output logic            THREE_MODE,
    output logic      [7:0] TAPE_REG_OUT,
    output logic      [1:0] BOOT_DRIVE,
    output logic      [1:0] DENSITY_SELECT,
    output logic      [7:0] DRIVE_TYPES,
    output logic            PRECOMP_DISABLE,
    output logic      [1:0] RATE_TABLE,
    output logic      [1:0] DRIVE0_TYPE
);
    logic [7:0] drv_if;
    logic [7:0] boot_wr;
    logic [7:0] dtype;
    logic [7:0] drv0x;
    logic [7:0] next_drv_if;
    logic [7:0] next_boot_wr;
    logic [7:0] next_dtype;
    logic [7:0] next_drv0x;

    // A write of the reserved mode code keeps the previous mode so the core never sees it.
    // Reserved bits of the drive 0 register are never stored, so they read back as zero.
    always_comb begin
        next_drv_if  = drv_if;
        next_boot_wr = boot_wr;
        next_dtype   = dtype;
        next_drv0x   = drv0x;
        if (WR) begin
            unique case (ADDR)
                fdcr_pkg::ADDR_DRV_IF: begin
                    next_drv_if = WDATA;
                    if (WDATA[fdcr_pkg::B_MODE_HI:fdcr_pkg::B_MODE_LO] == fdcr_pkg::MODE_RSVD) begin
                        next_drv_if[fdcr_pkg::B_MODE_HI:fdcr_pkg::B_MODE_LO] =
                            drv_if[fdcr_pkg::B_MODE_HI:fdcr_pkg::B_MODE_LO]; // see R10
                    end
                end
                fdcr_pkg::ADDR_BOOT_WR: next_boot_wr = WDATA;
                fdcr_pkg::ADDR_DTYPE:   next_dtype = WDATA; // see R11
                fdcr_pkg::ADDR_DRV0X:   next_drv0x = WDATA & fdcr_pkg::MASK_DRV0X;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            drv_if  <= fdcr_pkg::RST_DRV_IF;
            boot_wr <= fdcr_pkg::RST_BOOT_WR;
            dtype   <= fdcr_pkg::RST_DTYPE;
            drv0x   <= fdcr_pkg::RST_DRV0X;
        end else begin
            drv_if  <= next_drv_if;
            boot_wr <= next_boot_wr;
            dtype   <= next_dtype;
            drv0x   <= next_drv0x;
        end
    end

    // Unmapped addresses read as zero, and the data stand for one cycle only.
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = fdcr_pkg::READ_IDLE;
        if (RD) begin
            unique case (ADDR)
                fdcr_pkg::ADDR_DRV_IF:  next_rdata = drv_if;
                fdcr_pkg::ADDR_BOOT_WR: next_rdata = boot_wr;
                fdcr_pkg::ADDR_DTYPE:   next_rdata = dtype;
                fdcr_pkg::ADDR_DRV0X:   next_rdata = drv0x;
                default:                next_rdata = fdcr_pkg::READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= fdcr_pkg::READ_IDLE;
        end else begin
            RDATA <= next_rdata;
        end
    end

    logic       pol_high;
    logic       swap;
    logic       wr_inh;
    logic       force_wp;
    logic [4:0] pin_raw;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_c;
    logic [4:0] pin_filt;
    logic [4:0] next_sync_a;
    logic [4:0] next_sync_b;
    logic [4:0] next_sync_c;
    logic [4:0] next_pin_filt;

    assign pol_high = drv_if[fdcr_pkg::B_POL_HIGH];
    assign swap     = drv_if[fdcr_pkg::B_SWAP];
    assign wr_inh   = boot_wr[fdcr_pkg::B_WR_INH];
    assign force_wp = boot_wr[fdcr_pkg::B_FORCE_WP];

    // Pins are packed by named positions so the core side picks them out by the same names.
    assign pin_raw[fdcr_pkg::IN_READ_DATA]     = READ_DATA_IN;
    assign pin_raw[fdcr_pkg::IN_INDEX]         = INDEX_IN;
    assign pin_raw[fdcr_pkg::IN_TRACK_ZERO]    = TRACK_ZERO_IN;
    assign pin_raw[fdcr_pkg::IN_DISK_CHANGED]  = DISK_CHANGED_IN;
    assign pin_raw[fdcr_pkg::IN_WRITE_PROTECT] = WRITE_PROTECT_IN;

    // A bit of the filtered level moves only where the two later stages agree.
    // The third stage costs a cycle of latency, but a one-cycle glitch on a pin never reaches the core.
    always_comb begin
        next_sync_a   = pin_raw;
        next_sync_b   = sync_a;
        next_sync_c   = sync_b;
        next_pin_filt = (pin_filt & (sync_b ^ sync_c)) | (sync_c & ~(sync_b ^ sync_c));
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_a   <= fdcr_pkg::PIN_IN_IDLE;
            sync_b   <= fdcr_pkg::PIN_IN_IDLE;
            sync_c   <= fdcr_pkg::PIN_IN_IDLE;
            pin_filt <= fdcr_pkg::PIN_IN_IDLE;
        end else begin
            sync_a   <= next_sync_a;
            sync_b   <= next_sync_b;
            sync_c   <= next_sync_c;
            pin_filt <= next_pin_filt;
        end
    end

    logic [4:0] next_core_in;
    logic [4:0] core_in;

    // Forced protection wins over the pin, whatever the drive reports.
    always_comb begin
        next_core_in = pol_high ? pin_filt : ~pin_filt; // see R2
        if (force_wp) begin
            next_core_in[fdcr_pkg::IN_WRITE_PROTECT] = fdcr_pkg::LEVEL_ON; // see R9
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            core_in <= fdcr_pkg::RST_CORE_IN;
        end else begin
            core_in <= next_core_in;
        end
    end

    logic [1:0] next_dsel;
    logic [1:0] next_motor;
    logic [1:0] sel_int;
    logic [1:0] mot_int;

    // Swapping acts on the logical levels before polarity, so both settings combine freely.
    always_comb begin
        sel_int    = swap ? {CORE_DRIVE_SEL[0], CORE_DRIVE_SEL[1]} : CORE_DRIVE_SEL; // see R4
        mot_int    = swap ? {CORE_MOTOR_ON[0], CORE_MOTOR_ON[1]} : CORE_MOTOR_ON; // see R4
        next_dsel  = pol_high ? sel_int : ~sel_int; // see R2
        next_motor = pol_high ? mot_int : ~mot_int; // see R2
    end

    // The pin side lags the core by one cycle; polarity changes take effect on the next edge.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DRIVE_SEL_OUT <= {2{fdcr_pkg::PIN_IDLE}};
            MOTOR_OUT     <= {2{fdcr_pkg::PIN_IDLE}};
        end else begin
            DRIVE_SEL_OUT <= next_dsel;
            MOTOR_OUT     <= next_motor;
        end
    end

    logic next_wgate;
    logic next_wdata;

    // Inhibit holds both write pins high whatever the polarity setting.
    always_comb begin
        next_wgate = pol_high ? CORE_WRITE_GATE : ~CORE_WRITE_GATE; // see R2
        next_wdata = pol_high ? CORE_WRITE_DATA : ~CORE_WRITE_DATA; // see R2
        if (wr_inh) begin
            next_wgate = fdcr_pkg::PIN_IDLE; // see R8
            next_wdata = fdcr_pkg::PIN_IDLE; // see R8
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WRITE_GATE_OUT <= fdcr_pkg::PIN_IDLE;
            WRITE_DATA_OUT <= fdcr_pkg::PIN_IDLE;
        end else begin
            WRITE_GATE_OUT <= next_wgate;
            WRITE_DATA_OUT <= next_wdata;
        end
    end

    assign CORE_READ_DATA     = core_in[fdcr_pkg::IN_READ_DATA];
    assign CORE_INDEX         = core_in[fdcr_pkg::IN_INDEX];
    assign CORE_TRACK_ZERO    = core_in[fdcr_pkg::IN_TRACK_ZERO];
    assign CORE_DISK_CHANGED  = core_in[fdcr_pkg::IN_DISK_CHANGED];
    assign CORE_WRITE_PROTECT = core_in[fdcr_pkg::IN_WRITE_PROTECT];

    fdcr_pkg::fdcr_dma_t dma_state;
    fdcr_pkg::fdcr_dma_t next_dma_state;

    // Non-burst drops the request for one cycle after every acknowledged byte.
    always_comb begin
        next_dma_state = dma_state;
        unique case (dma_state)
            fdcr_pkg::DMA_IDLE: begin
                if (DMA_NONBURST && DMA_ACK) begin
                    next_dma_state = fdcr_pkg::DMA_GAP; // see R5
                end
            end
            fdcr_pkg::DMA_GAP: next_dma_state = fdcr_pkg::DMA_IDLE;
            default: next_dma_state = fdcr_pkg::DMA_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dma_state <= fdcr_pkg::DMA_IDLE;
        end else begin
            dma_state <= next_dma_state;
        end
    end

    // The gate is combinational so the request drops in the very cycle after the acknowledge.
    assign DMA_REQ = CORE_DRQ && (dma_state == fdcr_pkg::DMA_IDLE); // see R5

    // The media bits reach the tape register two cycles after the write, one cycle after the boot register.
    logic [7:0] next_tape;

    always_comb begin
        next_tape = {boot_wr[fdcr_pkg::B_MEDIA_HI:fdcr_pkg::B_MEDIA_LO], CORE_TAPE_LOW}; // see R7
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TAPE_REG_OUT <= fdcr_pkg::RST_TAPE;
        end else begin
            TAPE_REG_OUT <= next_tape;
        end
    end

    // Configuration fields leave the block straight from their register bits.
    assign INPUT_PULLUP_EN  = ~drv_if[fdcr_pkg::B_PULL_DIS]; // see R1
    assign SRA_SECOND_DRIVE = (INTERFACE_MODE == fdcr_pkg::MODE_SECOND) && !drv_if[fdcr_pkg::B_DRV2_N]; // see R3
    assign INTERFACE_MODE   = drv_if[fdcr_pkg::B_MODE_HI:fdcr_pkg::B_MODE_LO]; // see R10
    assign DMA_NONBURST     = drv_if[fdcr_pkg::B_NONBURST]; // see R5
    assign THREE_MODE       = drv_if[fdcr_pkg::B_THREE_MODE]; // see R6
    assign BOOT_DRIVE       = boot_wr[fdcr_pkg::B_BOOT_HI:fdcr_pkg::B_BOOT_LO];
    assign DENSITY_SELECT   = boot_wr[fdcr_pkg::B_DENS_HI:fdcr_pkg::B_DENS_LO];
    assign DRIVE_TYPES      = dtype; // see R11
    assign PRECOMP_DISABLE  = drv0x[fdcr_pkg::B_PRECOMP_DIS];
    assign RATE_TABLE       = drv0x[fdcr_pkg::B_RATE_HI:fdcr_pkg::B_RATE_LO];
    assign DRIVE0_TYPE      = drv0x[fdcr_pkg::B_D0TYPE_HI:fdcr_pkg::B_D0TYPE_LO];
endmodule // fdcr_top

// file: testbench/fdcr_top_monitor.sv
`timescale 1ns/1ps
module fdcr_monitor (
    input wire logic       SYS_CLK,
    input wire logic       ARST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic [1:0] CORE_DRIVE_SEL,
    input wire logic       DMA_ACK,
    input wire logic [1:0] DRIVE_SEL_OUT,
    input wire logic       WRITE_GATE_OUT,
    input wire logic       WRITE_DATA_OUT,
    input wire logic       INPUT_PULLUP_EN,
    input wire logic       CORE_WRITE_PROTECT,
    input wire logic       SRA_SECOND_DRIVE,
    input wire logic [1:0] INTERFACE_MODE,
    input wire logic       DMA_NONBURST,
    input wire logic       DMA_REQ,
    input wire logic [7:0] TAPE_REG_OUT,
    input wire logic [7:0] DRIVE_TYPES
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic wr_f0;
    logic wr_f1;
    assign wr_f0 = WR && ADDR == 8'hF0;
    assign wr_f1 = WR && ADDR == 8'hF1;
    property p_pullup; wr_f0 |=> INPUT_PULLUP_EN == !$past(WDATA[7]); endproperty
    a_pullup: assert property (p_pullup) else $error("Pull-up enable wrong.");
    property p_sel; wr_f0 |=> ##1 DRIVE_SEL_OUT == (($past(WDATA[4], 2) ? {$past(CORE_DRIVE_SEL[0]),
        $past(CORE_DRIVE_SEL[1])} : $past(CORE_DRIVE_SEL)) ^ {2{!$past(WDATA[6], 2)}}); endproperty
    a_sel: assert property (p_sel) else $error("Drive select pins wrong.");
    property p_sra; wr_f0 |=> SRA_SECOND_DRIVE == (INTERFACE_MODE == 2'h1 && !$past(WDATA[5])); endproperty
    a_sra: assert property (p_sra) else $error("Second drive flag wrong.");
    property p_gap; DMA_NONBURST && DMA_ACK && DMA_REQ |=> !DMA_REQ; endproperty
    a_gap: assert property (p_gap) else $error("Request not released between bytes.");
    property p_tape; wr_f1 |=> ##1 TAPE_REG_OUT[7:6] == $past(WDATA[5:4], 2); endproperty
    a_tape: assert property (p_tape) else $error("Media bits not reflected.");
    property p_inh; wr_f1 && WDATA[1] |=> ##1 WRITE_GATE_OUT && WRITE_DATA_OUT; endproperty
    a_inh: assert property (p_inh) else $error("Write pins not held high.");
    property p_wp; wr_f1 && WDATA[0] |-> ##[1:2] CORE_WRITE_PROTECT; endproperty
    a_wp: assert property (p_wp) else $error("Write protect not forced.");
    property p_mode; wr_f0 |=> INTERFACE_MODE == ($past(WDATA[3:2]) == 2'h2 ? $past(INTERFACE_MODE)
        : $past(WDATA[3:2])); endproperty
    a_mode: assert property (p_mode) else $error("Interface mode wrong.");
    property p_dtype; WR && ADDR == 8'hF2 |=> DRIVE_TYPES == $past(WDATA); endproperty
    a_dtype: assert property (p_dtype) else $error("Drive types wrong.");
    c_rsvd: cover property (wr_f0 && WDATA[3:2] == 2'h2);
    c_gap: cover property (DMA_NONBURST && DMA_ACK && DMA_REQ);
    c_inh: cover property (wr_f1 && WDATA[1]);
endmodule // fdcr_monitor
bind fdcr_top fdcr_monitor u_mon (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .CORE_DRIVE_SEL(CORE_DRIVE_SEL), .DMA_ACK(DMA_ACK), .DRIVE_SEL_OUT(DRIVE_SEL_OUT),
    .WRITE_GATE_OUT(WRITE_GATE_OUT), .WRITE_DATA_OUT(WRITE_DATA_OUT), .INPUT_PULLUP_EN(INPUT_PULLUP_EN),
    .CORE_WRITE_PROTECT(CORE_WRITE_PROTECT), .SRA_SECOND_DRIVE(SRA_SECOND_DRIVE), .DMA_REQ(DMA_REQ),
    .INTERFACE_MODE(INTERFACE_MODE), .DMA_NONBURST(DMA_NONBURST), .TAPE_REG_OUT(TAPE_REG_OUT),
    .DRIVE_TYPES(DRIVE_TYPES));

// file: testbench/fdcr_drive_model.sv
`timescale 1ns/1ps
module fdcr_drive_model (
    input  wire logic pol_high,
    input  wire logic sel0_pin,
    input  wire logic trk0_on,
    output logic      track_zero_pin,
    output logic      index_pin,
    output logic      wp_pin
);
    logic selected;
    // An unselected drive releases its outputs and the pull-up takes them high.
    assign selected       = (sel0_pin == pol_high);
    assign track_zero_pin = selected ? (trk0_on == pol_high) : 1'b1;
    assign index_pin      = selected ? !pol_high : 1'b1;
    assign wp_pin         = selected ? !pol_high : 1'b1;
endmodule // fdcr_drive_model

// file: testbench/fdcr_top_tb.sv
`timescale 1ns/1ps
module fdcr_top_tb;
    logic SYS_CLK = 0, ARST_N = 0, WR = 0, RD = 0, CORE_WRITE_GATE = 0, CORE_WRITE_DATA = 0, CORE_DRQ = 0;
    logic DMA_ACK = 0, pol_high = 0, trk0 = 0, trk_pin, idx_pin, wp_pin;
    logic [7:0] ADDR = 0, WDATA = 0, RDATA, TAPE_REG_OUT, DRIVE_TYPES;
    logic [1:0] CORE_DRIVE_SEL = 0, CORE_MOTOR_ON = 0, DRIVE_SEL_OUT, MOTOR_OUT, INTERFACE_MODE;
    logic WGATE_PIN, WDATA_PIN, PU, CTZ, CWP, SRA, NB, REQ, TM, CRD, CIDX, CDC, PRECOMP_DISABLE;
    logic [1:0] BOOT_DRIVE, DENSITY_SELECT, RATE_TABLE, DRIVE0_TYPE;
    int err_total = 0;
    int comparisons = 0;
    always #4 SYS_CLK = ~SYS_CLK;
    fdcr_drive_model u_drv (.pol_high(pol_high), .sel0_pin(DRIVE_SEL_OUT[0]), .trk0_on(trk0),
        .track_zero_pin(trk_pin), .index_pin(idx_pin), .wp_pin(wp_pin));
    fdcr_top u_dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .CORE_DRIVE_SEL(CORE_DRIVE_SEL), .CORE_MOTOR_ON(CORE_MOTOR_ON),
        .CORE_WRITE_GATE(CORE_WRITE_GATE), .CORE_WRITE_DATA(CORE_WRITE_DATA), .CORE_DRQ(CORE_DRQ),
        .DMA_ACK(DMA_ACK), .CORE_TAPE_LOW(6'h15), .READ_DATA_IN(1'b1), .INDEX_IN(idx_pin),
        .TRACK_ZERO_IN(trk_pin), .DISK_CHANGED_IN(1'b1), .WRITE_PROTECT_IN(wp_pin),
        .DRIVE_SEL_OUT(DRIVE_SEL_OUT), .MOTOR_OUT(MOTOR_OUT), .WRITE_GATE_OUT(WGATE_PIN),
        .WRITE_DATA_OUT(WDATA_PIN), .INPUT_PULLUP_EN(PU), .CORE_READ_DATA(CRD), .CORE_INDEX(CIDX),
        .CORE_TRACK_ZERO(CTZ), .CORE_DISK_CHANGED(CDC), .CORE_WRITE_PROTECT(CWP), .SRA_SECOND_DRIVE(SRA),
        .INTERFACE_MODE(INTERFACE_MODE), .DMA_NONBURST(NB), .DMA_REQ(REQ), .THREE_MODE(TM),
        .TAPE_REG_OUT(TAPE_REG_OUT), .BOOT_DRIVE(BOOT_DRIVE), .DENSITY_SELECT(DENSITY_SELECT),
        .DRIVE_TYPES(DRIVE_TYPES), .PRECOMP_DISABLE(PRECOMP_DISABLE), .RATE_TABLE(RATE_TABLE),
        .DRIVE0_TYPE(DRIVE0_TYPE));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge SYS_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge SYS_CLK);
        WR <= 1'b0;
        @(posedge SYS_CLK);
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge SYS_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1;
        check("rdata", RDATA, exp);
    endtask
    task automatic t_regs;
        check("pullup", 8'(PU), 8'h00);
        rd(8'hF0, fdcr_pkg::RST_DRV_IF);
        @(posedge SYS_CLK);
        #1;
        check("rdata idle", RDATA, fdcr_pkg::READ_IDLE);
        rd(8'hF1, fdcr_pkg::RST_BOOT_WR);
        rd(8'hF2, fdcr_pkg::RST_DTYPE);
        rd(8'hF4, fdcr_pkg::RST_DRV0X);
        rd(8'hF3, 8'h00);
        wr(8'hF2, 8'h1B);
        check("types", DRIVE_TYPES, 8'h1B);
        wr(8'hF4, 8'hFF);
        check("precomp", 8'(PRECOMP_DISABLE), 8'h01);
        check("rate table", 8'(RATE_TABLE), 8'h03);
        check("drive0 type", 8'(DRIVE0_TYPE), 8'h03);
        rd(8'hF4, fdcr_pkg::MASK_DRV0X);
        wr(8'hF1, 8'hC8);
        check("boot drive", 8'(BOOT_DRIVE), 8'h03);
        check("density", 8'(DENSITY_SELECT), 8'h02);
        rd(8'hF1, 8'hC8);
        wr(8'hF0, 8'h0E);
        check("pullup", 8'(PU), 8'h01);
        $display("test regs done");
    endtask
    task automatic t_drive;
        @(posedge SYS_CLK);
        CORE_DRIVE_SEL <= 2'b01;
        CORE_MOTOR_ON <= 2'b10;
        wr(8'hF0, 8'h40);
        check("sel", 8'(DRIVE_SEL_OUT), 8'h01);
        check("motor", 8'(MOTOR_OUT), 8'h02);
        wr(8'hF0, 8'h50);
        check("sel", 8'(DRIVE_SEL_OUT), 8'h02);
        check("motor", 8'(MOTOR_OUT), 8'h01);
        wr(8'hF0, 8'h10);
        check("sel", 8'(DRIVE_SEL_OUT), 8'h01);
        wr(8'hF0, 8'h18);
        rd(8'hF0, 8'h10);
        $display("test drive done");
    endtask
    task automatic t_modes;
        logic [1:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 2) ? 2'h3 : 2'(i);
            wr(8'hF0, {4'h0, m, 1'b0, m[0]});
            check("mode", 8'(INTERFACE_MODE), 8'(m));
            check("sra", 8'(SRA), 8'(m == 2'h1));
            check("three", 8'(TM), 8'(m[0]));
        end
        wr(8'hF0, 8'h24);
        check("sra", 8'(SRA), 8'h00);
        $display("test modes done");
    endtask
    task automatic t_media;
        wr(8'hF0, 8'h00);
        @(posedge SYS_CLK);
        CORE_WRITE_GATE <= 1'b1;
        CORE_WRITE_DATA <= 1'b1;
        wr(8'hF1, 8'h32);
        check("gate", {WGATE_PIN, WDATA_PIN}, 8'h03);
        check("tape", TAPE_REG_OUT, 8'hD5);
        wr(8'hF1, 8'h01);
        check("gate", {WGATE_PIN, WDATA_PIN}, 8'h00);
        check("wp", 8'(CWP), 8'h01);
        wr(8'hF1, 8'h20);
        repeat (8) @(posedge SYS_CLK);
        #1;
        check("wp", 8'(CWP), 8'h00);
        check("tape", TAPE_REG_OUT, 8'h95);
        $display("test media done");
    endtask
    task automatic t_dma(logic [7:0] cfg, logic [7:0] gap);
        wr(8'hF0, cfg);
        check("nonburst", 8'(NB), 8'(cfg[1]));
        @(posedge SYS_CLK);
        CORE_DRQ <= 1'b1;
        @(posedge SYS_CLK);
        DMA_ACK <= 1'b1;
        @(posedge SYS_CLK);
        DMA_ACK <= 1'b0;
        #1;
        check("req", 8'(REQ), gap);
        @(posedge SYS_CLK);
        #1;
        check("req", 8'(REQ), 8'h01);
        $display("test dma done");
    endtask
    task automatic t_pins(logic [7:0] cfg);
        wr(8'hF0, cfg);
        pol_high <= cfg[6];
        trk0 <= 1'b1;
        repeat (8) @(posedge SYS_CLK);
        #1;
        check("trk0", 8'(CTZ), 8'h01);
        check("rdata pin", 8'(CRD), 8'(cfg[6]));
        check("disk change", 8'(CDC), 8'(cfg[6]));
        check("index", 8'(CIDX), 8'h00);
        trk0 <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        #1;
        check("trk0", 8'(CTZ), 8'h00);
        $display("test pins done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Generous bound: the whole sequence needs well under a thousand cycles.
    initial begin
        #50000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        t_regs();
        t_drive();
        t_modes();
        t_media();
        t_dma(8'h02, 8'h00);
        t_dma(8'h00, 8'h01);
        t_pins(8'h00);
        t_pins(8'h40);
        print_verdict();
    end
endmodule // fdcr_top_tb
